// ---- clb_defines.svh ----
// constants for the configurable logic block
`ifndef CLB_DEFINES_SVH
`define CLB_DEFINES_SVH

// ==========================================
// array sizes
`define CLB_NUM_IN 34
`define CLB_NUM_PT 90
`define CLB_NUM_LOGIC_PT 80
`define CLB_OE_PT_BASE 80
`define CLB_INIT_PT_BASE 88
`define CLB_NUM_INIT_PT 2
`define CLB_PT_PER_CLUSTER 5
`define CLB_NUM_MC 16
`define CLB_NUM_IO 8
`define CLB_NUM_GCLK 4
`define CLB_NUM_BCLK 4
`define CLB_NUM_ISW_SRC 32
`define CLB_NUM_ISW_OUT 24
`define CLB_MC_PER_IO 8

// ==========================================
// allocation limits
`define CLB_SYNC_MAX_PT 20
`define CLB_ASYNC_MAX_PT 18
`define CLB_TAKE_WIDTH 4

// ==========================================
// reset value of all state
`define CLB_STATE_RESET '0

`endif

// ---- clb_logic_block.sv ----
// configurable logic block: terms, allocator, macrocells, switches
`timescale 1ns/1ns
`default_nettype none
`include "clb_defines.svh"

// Notes on behaviour
// - four block clocks each pick one of eight: any global clock, true or inverted
// - every macrocell and I/O cell may use any block clock, either mode
// - array gives 80 logic terms, eight enable terms, two block init terms
// - sixteen macrocells, eight I/O cells, ninety terms in all
// - each macrocell owns one five-term cluster that may be lent out
// - a macrocell gathers up to 20 terms synchronous, 18 asynchronous
// - a lent cluster gives all five terms, or four keeping one home, in synchronous mode; three, or two keeping one, in asynchronous
// - macrocell n takes clusters n-1 to n+2 within 0 to 15
// - each macrocell path has an XOR gate for logic and register emulation
// - each pin driver is enabled by its own term
// - block init terms reset or preset synchronous-mode flip-flops asynchronously
// - either init term initializes all synchronous-mode flip-flops together
// - input switch picks 24 of 16 feedbacks, 8 registered, 8 pin inputs
// - macrocells reach pins only through one of four I/O cells each
// - macrocell output is registered or combinational with selectable polarity
// - register works as D, T, JK, SR flip-flop or transparent latch
// - synchronous or asynchronous mode is chosen per macrocell alone
module clb_logic_block (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [`CLB_NUM_IN-1:0] matrix_in,
  input wire logic [`CLB_NUM_GCLK-1:0] gclk,
  input wire logic [`CLB_NUM_IO-1:0] pin_in,
  input wire clb_pkg::blk_cfg_t cfg,
  output logic [`CLB_NUM_IO-1:0] pin_out,
  output logic [`CLB_NUM_IO-1:0] pin_oe,
  output logic [`CLB_NUM_ISW_OUT-1:0] to_matrix
);
  import clb_pkg::*;

  // ==========================================
  // decoders
  function automatic logic term_eval(input term_cfg_t t, input logic [`CLB_NUM_IN-1:0] x);
    term_eval = (|(t.use_true | t.use_comp)) & (&(~t.use_true | x)) & (&(~t.use_comp | ~x));
  endfunction : term_eval

  function automatic logic pick4(input logic [3:0] v, input logic [1:0] sel);
    pick4 = v[sel];
  endfunction : pick4

  function automatic logic [3:0] mc_for_io(input logic [2:0] j, input logic [2:0] pick);
    mc_for_io = {j, 1'b0} + {1'b0, pick};
  endfunction : mc_for_io

  // ==========================================
  // state and wiring
  blk_state_t st_reg;
  blk_state_t st_next;
  logic [`CLB_NUM_PT-1:0] pt;
  logic [`CLB_NUM_BCLK-1:0] sel_clk;
  logic [`CLB_NUM_BCLK-1:0] clk_rise;
  logic [`CLB_NUM_MC-1:0] cl_first;
  logic [`CLB_NUM_MC-1:0] cl_rest;
  logic [`CLB_NUM_MC-1:0] cl_all;
  logic [`CLB_NUM_MC-1:0] cl_shared;
  logic [`CLB_NUM_MC-1:0] mc_sum;
  logic [`CLB_NUM_MC-1:0] mc_aux;
  logic [`CLB_NUM_MC-1:0] mc_d;
  logic [`CLB_NUM_MC-1:0] mc_ares;
  logic [`CLB_NUM_MC-1:0] mc_apre;
  logic [`CLB_NUM_MC-1:0] mc_fb;
  logic [`CLB_NUM_MC-1:0] mc_out;
  logic [`CLB_NUM_MC-1:0] sync_mask;
  logic [`CLB_NUM_MC-1:0] dff_mask;
  logic [`CLB_NUM_MC-1:0] latch_hold_mask;
  logic [`CLB_NUM_IO-1:0] oe_terms;
  logic [`CLB_NUM_IO-1:0] io_pick_val;
  logic [`CLB_NUM_ISW_SRC-1:0] isw_src;
  logic binit_on;
  logic binit_val;

  // ==========================================
  // product-term array
  genvar g;
  generate
    for (g = 0; g < `CLB_NUM_PT; g++) begin : g_term
      assign pt[g] = term_eval(cfg.term[g], matrix_in);
    end
  endgenerate

  assign oe_terms = pt[`CLB_OE_PT_BASE +: `CLB_NUM_IO];
  assign binit_on = |pt[`CLB_INIT_PT_BASE +: `CLB_NUM_INIT_PT];
  assign binit_val = pt[`CLB_INIT_PT_BASE] ? cfg.init_is_preset[0] : cfg.init_is_preset[1];

  // ==========================================
  // clock generator
  generate
    for (g = 0; g < `CLB_NUM_BCLK; g++) begin : g_clk
      assign sel_clk[g] = gclk[cfg.clk_pick[g].pin] ^ cfg.clk_pick[g].invert;
    end
  endgenerate

  assign clk_rise = sel_clk & ~st_reg.clk_prev;

  // ==========================================
  // clusters
  generate
    for (g = 0; g < `CLB_NUM_MC; g++) begin : g_cluster
      logic [`CLB_PT_PER_CLUSTER-1:0] t;
      logic reserve;
      assign t = pt[`CLB_PT_PER_CLUSTER*g +: `CLB_PT_PER_CLUSTER];
      // asynchronous mode keeps two terms for the cell's own reset and preset
      assign reserve = cfg.mc[g].async_mode;
      assign cl_first[g] = reserve ? t[2] : t[0];
      assign cl_rest[g] = reserve ? (|t[4:3]) : (|t[4:1]);
      assign cl_all[g] = cl_first[g] | cl_rest[g];
      // lend four and keep one, or lend all five; in asynchronous mode lend two and keep one, or lend three
      assign cl_shared[g] = cfg.cluster[g].steer_away
        ? (cfg.cluster[g].keep_one ? cl_rest[g] : cl_all[g]) : 1'b0;
      assign mc_ares[g] = reserve & t[0];
      assign mc_apre[g] = reserve & t[1];
    end
  endgenerate

  // ==========================================
  // logic allocator per macrocell
  generate
    for (g = 0; g < `CLB_NUM_MC; g++) begin : g_alloc
      logic [`CLB_TAKE_WIDTH-1:0] gath;
      logic aux_used;
      logic home;
      genvar k;
      for (k = 0; k < `CLB_TAKE_WIDTH; k++) begin : g_take
        localparam int CI = g - 1 + k;
        if (CI >= 0 && CI < `CLB_NUM_MC && CI != g) begin : g_ok
          assign gath[k] = cfg.mc[g].take[k] & cl_shared[CI];
        end else begin : g_none
          assign gath[k] = 1'b0;
        end
      end
      assign aux_used = cfg.mc[g].xor_en | (cfg.mc[g].kind == REG_JK) | (cfg.mc[g].kind == REG_SR);
      assign home = cfg.cluster[g].steer_away
        ? (cfg.cluster[g].keep_one & ~aux_used & cl_first[g])
        : (aux_used ? cl_rest[g] : cl_all[g]);
      assign mc_sum[g] = home | (|gath);
      assign mc_aux[g] = cl_first[g];
      assign mc_d[g] = mc_sum[g] ^ (cfg.mc[g].xor_en & mc_aux[g]);
      assign mc_fb[g] = cfg.mc[g].registered ? st_reg.mc_q[g] : mc_d[g];
      assign mc_out[g] = mc_fb[g] ^ cfg.mc[g].invert_out;
      assign sync_mask[g] = ~cfg.mc[g].async_mode;
      assign dff_mask[g] = sync_mask[g] & ~binit_on & (cfg.mc[g].kind == REG_D)
        & pick4(clk_rise, cfg.mc[g].clk_sel);
      assign latch_hold_mask[g] = (cfg.mc[g].kind == REG_LATCH) & ~pick4(sel_clk, cfg.mc[g].clk_sel)
        & ~(sync_mask[g] & binit_on) & ~mc_ares[g] & ~mc_apre[g];
    end
  endgenerate

  // ==========================================
  // output and input switches
  generate
    for (g = 0; g < `CLB_NUM_IO; g++) begin : g_io
      assign io_pick_val[g] = mc_out[mc_for_io(3'(g), cfg.io[g].mc_pick)];
    end
  endgenerate

  assign isw_src = {pin_in, st_reg.pin_q, mc_fb};

  // ==========================================
  // next state
  always_comb begin
    logic q;
    logic edge_hit;
    logic lvl;
    q = 1'b0;
    edge_hit = 1'b0;
    lvl = 1'b0;
    st_next = st_reg;
    if (srst) begin
      st_next = `CLB_STATE_RESET;
    end else if (ce) begin
      st_next.clk_prev = sel_clk;
      for (int n = 0; n < `CLB_NUM_MC; n++) begin
        q = st_reg.mc_q[n];
        edge_hit = pick4(clk_rise, cfg.mc[n].clk_sel);
        lvl = pick4(sel_clk, cfg.mc[n].clk_sel);
        case (cfg.mc[n].kind)
          REG_D: begin
            if (edge_hit) begin
              q = mc_d[n];
            end
          end
          REG_T: begin
            if (edge_hit) begin
              q = st_reg.mc_q[n] ^ mc_d[n];
            end
          end
          REG_JK: begin
            if (edge_hit) begin
              case ({mc_d[n], mc_aux[n]})
                2'b10: q = 1'b1;
                2'b01: q = 1'b0;
                2'b11: q = ~st_reg.mc_q[n];
                default: q = st_reg.mc_q[n];
              endcase
            end
          end
          REG_SR: begin
            if (edge_hit) begin
              if (mc_aux[n]) begin
                q = 1'b0;
              end else if (mc_d[n]) begin
                q = 1'b1;
              end
            end
          end
          REG_LATCH: begin
            if (lvl) begin
              q = mc_d[n];
            end
          end
          default: begin
            q = st_reg.mc_q[n];
          end
        endcase
        if (sync_mask[n] && binit_on) begin
          q = binit_val;
        end else if (mc_ares[n]) begin
          q = 1'b0;
        end else if (mc_apre[n]) begin
          q = 1'b1;
        end
        st_next.mc_q[n] = q;
      end
      for (int j = 0; j < `CLB_NUM_IO; j++) begin
        if (pick4(clk_rise, cfg.io[j].clk_sel)) begin
          st_next.pin_q[j] = pin_in[j];
        end
        st_next.pin_out[j] = io_pick_val[j];
        st_next.pin_oe[j] = oe_terms[j];
      end
      for (int i = 0; i < `CLB_NUM_ISW_OUT; i++) begin
        st_next.to_matrix[i] = isw_src[cfg.isw_pick[i]];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    st_reg <= st_next;
  end

  assign pin_out = st_reg.pin_out;
  assign pin_oe = st_reg.pin_oe;
  assign to_matrix = st_reg.to_matrix;

  // ==========================================
  // checks
  property p_oe;
    @(posedge ref_clk) disable iff (srst)
    ce |=> pin_oe == $past(oe_terms);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable does not follow its own term");

  property p_block_init;
    @(posedge ref_clk) disable iff (srst)
    (ce && binit_on) |=> ((st_reg.mc_q ^ {`CLB_NUM_MC{$past(binit_val)}}) & $past(sync_mask)) == '0;
  endproperty
  a_block_init: assert property (p_block_init) else $error("synchronous cells missed block init");

  property p_async_reset;
    @(posedge ref_clk) disable iff (srst)
    ce |=> (st_reg.mc_q & $past(mc_ares) & ~$past(sync_mask)) == '0;
  endproperty
  a_async_reset: assert property (p_async_reset) else $error("async cell reset term ignored");

  property p_dff;
    @(posedge ref_clk) disable iff (srst)
    ce |=> ((st_reg.mc_q ^ $past(mc_d)) & $past(dff_mask)) == '0;
  endproperty
  a_dff: assert property (p_dff) else $error("D cell did not capture on its clock edge");

  property p_latch_hold;
    @(posedge ref_clk) disable iff (srst)
    ce |=> ((st_reg.mc_q ^ $past(st_reg.mc_q)) & $past(latch_hold_mask)) == '0;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("closed latch changed");

  property p_outsel;
    @(posedge ref_clk) disable iff (srst)
    ce |=> pin_out == $past(io_pick_val);
  endproperty
  a_outsel: assert property (p_outsel) else $error("pin driven by wrong macrocell");

  property p_pin_path;
    @(posedge ref_clk) disable iff (srst)
    (ce && cfg.isw_pick[0] >= 5'h18) |=> to_matrix[0] == $past(pin_in[cfg.isw_pick[0][2:0]]);
  endproperty
  a_pin_path: assert property (p_pin_path) else $error("pin input lost on way to matrix");

  property p_fb_path;
    @(posedge ref_clk) disable iff (srst)
    (ce && cfg.isw_pick[1] < 5'h10) |=> to_matrix[1] == $past(mc_fb[cfg.isw_pick[1][3:0]]);
  endproperty
  a_fb_path: assert property (p_fb_path) else $error("feedback lost on way to matrix");

  property p_async_preset;
    @(posedge ref_clk) disable iff (srst)
    ce |=> (~st_reg.mc_q & $past(mc_apre) & ~$past(mc_ares) & ~$past(sync_mask)) == '0;
  endproperty
  a_async_preset: assert property (p_async_preset) else $error("async cell preset term ignored");

  property p_tff;
    @(posedge ref_clk) disable iff (srst)
    (ce && cfg.mc[1].kind == REG_T && pick4(clk_rise, cfg.mc[1].clk_sel) && !binit_on && !mc_ares[1] && !mc_apre[1])
      |=> st_reg.mc_q[1] == $past(st_reg.mc_q[1] ^ mc_d[1]);
  endproperty
  a_tff: assert property (p_tff) else $error("T cell did not toggle by its input");

  property p_latch_open;
    @(posedge ref_clk) disable iff (srst)
    (ce && cfg.mc[3].kind == REG_LATCH && pick4(sel_clk, cfg.mc[3].clk_sel) && !(sync_mask[3] && binit_on)
      && !mc_ares[3] && !mc_apre[3]) |=> st_reg.mc_q[3] == $past(mc_d[3]);
  endproperty
  a_latch_open: assert property (p_latch_open) else $error("open latch did not follow its input");

  generate
    for (g = 0; g < `CLB_NUM_MC; g++) begin : g_chk_steer
      property p_steer_all;
        @(posedge ref_clk) disable iff (srst)
        (cfg.cluster[g].steer_away && !cfg.cluster[g].keep_one && cfg.mc[g].take == '0) |-> !mc_sum[g];
      endproperty
      a_steer_all: assert property (p_steer_all) else $error("fully lent cluster still feeds its cell");
    end
  endgenerate

  property p_clk_track;
    @(posedge ref_clk) disable iff (srst)
    ce |=> st_reg.clk_prev[0] == ($past(gclk[cfg.clk_pick[0].pin]) ^ cfg.clk_pick[0].invert);
  endproperty
  a_clk_track: assert property (p_clk_track) else $error("block clock not from chosen pin");

  property p_freeze;
    @(posedge ref_clk) disable iff (srst)
    !ce |=> $stable(st_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

endmodule : clb_logic_block
`default_nettype wire

// ---- clb_pkg.sv ----
// types for the configurable logic block
package clb_pkg;
`include "clb_defines.svh"

  // ==========================================
  // register kind, one-hot
  typedef enum logic [4:0] {
    REG_D = 5'h01,
    REG_T = 5'h02,
    REG_JK = 5'h04,
    REG_SR = 5'h08,
    REG_LATCH = 5'h10
  } reg_kind_t;

  // ==========================================
  // configuration fields
  typedef struct packed {
    logic invert;
    logic [1:0] pin;
  } clk_pick_t;

  typedef struct packed {
    logic [`CLB_NUM_IN-1:0] use_true;
    logic [`CLB_NUM_IN-1:0] use_comp;
  } term_cfg_t;

  typedef struct packed {
    logic steer_away;
    logic keep_one;
  } cluster_cfg_t;

  typedef struct packed {
    logic async_mode;
    logic [`CLB_TAKE_WIDTH-1:0] take;
    logic xor_en;
    logic registered;
    logic invert_out;
    reg_kind_t kind;
    logic [1:0] clk_sel;
  } mc_cfg_t;

  typedef struct packed {
    logic [2:0] mc_pick;
    logic [1:0] clk_sel;
  } io_cfg_t;

  typedef struct packed {
    term_cfg_t [`CLB_NUM_PT-1:0] term;
    clk_pick_t [`CLB_NUM_BCLK-1:0] clk_pick;
    cluster_cfg_t [`CLB_NUM_MC-1:0] cluster;
    mc_cfg_t [`CLB_NUM_MC-1:0] mc;
    io_cfg_t [`CLB_NUM_IO-1:0] io;
    logic [`CLB_NUM_INIT_PT-1:0] init_is_preset;
    logic [`CLB_NUM_ISW_OUT-1:0][4:0] isw_pick;
  } blk_cfg_t;

  // ==========================================
  // all state of the block
  typedef struct packed {
    logic [`CLB_NUM_BCLK-1:0] clk_prev;
    logic [`CLB_NUM_MC-1:0] mc_q;
    logic [`CLB_NUM_IO-1:0] pin_q;
    logic [`CLB_NUM_IO-1:0] pin_out;
    logic [`CLB_NUM_IO-1:0] pin_oe;
    logic [`CLB_NUM_ISW_OUT-1:0] to_matrix;
  } blk_state_t;

endpackage : clb_pkg

// ---- configurable_logic_block_tb.sv ----
// self-checking testbench for the configurable logic block
`timescale 1ns/1ns
`default_nettype none
`include "clb_defines.svh"

// ==========================================
// testbench top
module configurable_logic_block_tb;
  import clb_pkg::*;
  logic ref_clk;
  logic srst;
  logic ce;
  logic [`CLB_NUM_IN-1:0] ext_in;
  logic [`CLB_NUM_IN-1:0] matrix_in;
  logic [3:0] gclk;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [23:0] to_matrix;
  blk_cfg_t cfg;
  int n_mismatch;
  int cmp_count;

  matrix_model matrix_model_inst (
    .ext_in(ext_in),
    .matrix_in(matrix_in)
  );

  clb_logic_block clb_logic_block_inst (
    .ref_clk(ref_clk),
    .srst(srst),
    .ce(ce),
    .matrix_in(matrix_in),
    .gclk(gclk),
    .pin_in(pin_in),
    .cfg(cfg),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .to_matrix(to_matrix)
  );

  // ==========================================
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ==========================================
  // tasks
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic drive(input logic [`CLB_NUM_IN-1:0] m, input logic [3:0] g);
    @(posedge ref_clk);
    ext_in <= m;
    gclk <= g;
  endtask : drive

  task automatic check_bits(input string name, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check_bits

  task automatic check_outs(input logic [7:0] e_out, input logic [7:0] e_oe, input logic [23:0] e_tm);
    check_bits("pin_out", {16'h0, e_out}, {16'h0, pin_out});
    check_bits("pin_oe", {16'h0, e_oe}, {16'h0, pin_oe});
    check_bits("to_matrix", e_tm, to_matrix);
  endtask : check_outs

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================
  // hang guard
  initial begin
    repeat (2000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end

  // ==========================================
  // main sequence
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    srst = 1'b1;
    ce = 1'b1;
    ext_in = '0;
    gclk = 4'h4;
    pin_in = 8'h20;
    cfg = '0;
    cfg.term[0].use_true[0] = 1'b1;
    cfg.term[80].use_true[1] = 1'b1;
    cfg.term[10].use_true[2] = 1'b1;
    cfg.term[30].use_true[3] = 1'b1;
    cfg.term[88].use_true[33] = 1'b1;
    cfg.term[25].use_true[0] = 1'b1;
    cfg.mc[5].async_mode = 1'b1;
    cfg.mc[1].kind = REG_T;
    cfg.mc[3].kind = REG_LATCH;
    cfg.clk_pick[0].pin = 2'h2;
    cfg.clk_pick[0].invert = 1'b1;
    cfg.mc[0].registered = 1'b1;
    cfg.mc[0].kind = REG_D;
    cfg.mc[2].invert_out = 1'b1;
    cfg.mc[4].take = 4'h8;
    cfg.cluster[6].steer_away = 1'b1;
    cfg.isw_pick[0] = 5'h1D;
    repeat (9) @(posedge ref_clk);
    #1;
    check_outs(8'h00, 8'h00, 24'h000000);
    @(posedge ref_clk);
    srst <= 1'b0;
    // enable term, polarity, borrowed cluster, raw pin path
    for (int v = 0; v < 8; v++) begin
      drive({30'h0, v[2:0], 1'b0}, 4'h4);
      tick(1);
      check_outs({5'h0, v[2], ~v[1], 1'b0}, {7'h0, v[0]}, 24'h000001);
    end
    // d held high, no block clock edge yet
    drive(34'h1, 4'h4);
    tick(2);
    check_outs(8'h02, 8'h00, 24'h000001);
    // falling global pin is a rising inverted block clock
    drive(34'h1, 4'h0);
    tick(2);
    check_outs(8'h03, 8'h00, 24'hFFFFFF);
    // block init term clears the synchronous flip-flop
    drive({1'b1, 33'h1}, 4'h0);
    tick(2);
    check_outs(8'h02, 8'h00, 24'h000001);
    drive(34'h1, 4'h0);
    tick(2);
    check_outs(8'h02, 8'h00, 24'h000001);
    drive(34'h1, 4'h4);
    drive(34'h1, 4'h0);
    tick(2);
    check_outs(8'h03, 8'h00, 24'hFFFFFF);
    // clock enable low freezes outputs
    @(posedge ref_clk);
    ce <= 1'b0;
    ext_in <= 34'h3;
    tick(2);
    check_outs(8'h03, 8'h00, 24'hFFFFFF);
    @(posedge ref_clk);
    ce <= 1'b1;
    pin_in <= 8'h00;
    tick(1);
    check_outs(8'h03, 8'h01, 24'hFFFFFE);
    tally_and_finish();
  end
endmodule : configurable_logic_block_tb

`default_nettype wire

// ---- matrix_model.sv ----
// model of the central switch matrix feeding one logic block
`timescale 1ns/1ns
`default_nettype none
`include "clb_defines.svh"

// ==========================================
// matrix model
module matrix_model (
  input wire logic [`CLB_NUM_IN-1:0] ext_in,
  output logic [`CLB_NUM_IN-1:0] matrix_in
);
  // exactly 34 lines into the array
  assign matrix_in = ext_in;
endmodule : matrix_model

`default_nettype wire
